// ===== design/spl_pkg.sv
// Shared constants, tables and types of the speaker protection limiters
package spl_pkg;

	// ****************************************
	// Register map and field positions
	// ****************************************
	localparam logic [7:0] ADDR_CORNER = 8'h41;
	localparam logic [7:0] ADDR_THRESH = 8'h42;
	localparam logic [7:0] ADDR_RELEASE = 8'h43;
	localparam logic [7:0] ADDR_PWR_TW = 8'h44;
	localparam logic [7:0] ADDR_PWR_TC = 8'h45;
	localparam logic [7:0] ADDR_DIST = 8'h46;
	localparam int UPPER_LSB = 4;
	localparam int LOWER_LSB = 0;
	localparam int RELEASE_LSB = 4;
	localparam int THRESH_LSB = 0;
	localparam int POWER_THRESHOLD_SEL_LSB = 4;
	localparam int WEIGHT_LSB = 0;
	localparam int MAGNET_LSB = 4;
	localparam int COIL_LSB = 0;
	localparam int DLIM_LSB = 4;
	localparam int DREL_LSB = 0;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_KHZ = 250000;
	localparam int EXC_MIN_RELEASE_MS = 250;
	localparam int DIST_RELEASE_MS = 1400;
	localparam int MUTE_MS = 10;
	localparam int TC_UNIT_MS = 10;
	localparam logic [7:0] SLIDE_FULL = 8'hff;
	localparam logic [4:0] ATTEN_MAX = 5'h1f;
	localparam int FILT_SHIFT = 6;
	localparam int EXC_STEP_CYCLES = EXC_MIN_RELEASE_MS * CLK_KHZ / 255;
	localparam int DIST_STEP_CYCLES = DIST_RELEASE_MS * CLK_KHZ / 31;
	localparam int MUTE_CYCLES = MUTE_MS * CLK_KHZ;
	localparam int PWR_TICK_CYCLES = TC_UNIT_MS * CLK_KHZ / (1 << FILT_SHIFT);
	localparam logic [15:0] SEC_PER_MIN = 16'h003c;

	// ****************************************
	// Code tables
	// ****************************************
	localparam logic [10:0] UPPER_HZ [0:4] = '{11'd0, 11'd400, 11'd600, 11'd800, 11'd1000};
	localparam logic [12:0] EXC_THR_MV [0:7] = '{13'd340, 13'd710, 13'd1300, 13'd1770,
		13'd2330, 13'd3250, 13'd4250, 13'd4950};
	localparam logic [2:0] REL_SHIFT [0:7] = '{3'd4, 3'd3, 3'd2, 3'd1, 3'd0, 3'd0, 3'd0, 3'd0};
	localparam logic [10:0] PWR_THR_MW [0:15] = '{11'd0, 11'd50, 11'd60, 11'd90, 11'd110,
		11'd130, 11'd180, 11'd220, 11'd270, 11'd350, 11'd480, 11'd720, 11'd1000, 11'd1430,
		11'd1570, 11'd1800};
	localparam logic [3:0] COIL_EIGHTHS [0:7] = '{4'd4, 4'd5, 4'd6, 4'd7, 4'd8, 4'd1, 4'd2, 4'd3};
	localparam logic [3:0] WEIGHT_ALL = 4'h8;
	localparam logic [15:0] TC_CS [0:15] = '{16'd0, 16'd50, 16'd67, 16'd89, 16'd119, 16'd158,
		16'd211, 16'd281, 16'd375, 16'd500, 16'd666, 16'd888, 16'd0, 16'd0, 16'd0, 16'd0};
	localparam logic [7:0] THD_PERMILLE [0:15] = '{8'd0, 8'd5, 8'd10, 8'd20, 8'd40, 8'd60,
		8'd80, 8'd100, 8'd120, 8'd140, 8'd160, 8'd180, 8'd200, 8'd210, 8'd220, 8'd240};

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		EXC_OFF = 3'b000,
		EXC_FIXED_PRESET = 3'b001,
		EXC_FIXED_BIQUAD = 3'b010,
		EXC_DYN_PRESET = 3'b011,
		EXC_DYN_BIQUAD = 3'b100,
		EXC_INVALID = 3'b101
	} spl_exc_mode_t;

	typedef struct packed {
		spl_exc_mode_t mode;
		logic [10:0] upper_hz;
		logic [10:0] lower_hz;
		logic [7:0] slide;
	} spl_exc_ctl_t;

	typedef struct packed {
		logic mute;
		logic [4:0] atten;
	} spl_vol_ctl_t;

endpackage : spl_pkg

// ===== design/spl_thermal_filter.sv
// One-pole thermal averaging filter for the power limiter
`timescale 1ns/1ps
`default_nettype none
module spl_thermal_filter (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Control
	input wire logic tick,
	input wire logic [15:0] interval,
	// Data
	input wire logic [10:0] power_mw,
	output logic [10:0] avg_mw
);
	logic [15:0] cnt_r;
	logic [16:0] acc_r;
	logic [16:0] target;
	logic step;

	// Interval zero disables the filter and clears its history
	assign target = {power_mw, 6'h00};
	assign step = tick && (cnt_r + 16'h0001 >= interval);

	// Divide the base tick by the selected time constant
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 16'h0000;
		end else if (ce) begin
			if (interval == 16'h0000 || step) begin
				cnt_r <= 16'h0000;
			end else if (tick) begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end

	// Exponential average, 1/64 per step so 64 steps are one time constant
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			acc_r <= 17'h0_0000;
		end else if (ce) begin
			if (interval == 16'h0000) begin
				acc_r <= 17'h0_0000;
			end else if (step) begin
				acc_r <= 17'(acc_r + (target >>> spl_pkg::FILT_SHIFT) - (acc_r >> spl_pkg::FILT_SHIFT));
			end
		end
	end

	assign avg_mw = acc_r[16:6];
endmodule : spl_thermal_filter
`default_nettype wire

// ===== design/spl_limiters.sv
// Speaker protection: excursion, power and distortion limiters
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - Lower 00: fixed highpass at upper corner 400/600/800/1000 Hz.
// R2 - Biquad fixed, preset sliding pairs, or biquad-to-upper sliding modes.
// R3 - Release code sets slide time 4, 2, 1, 0.5, 0.25 s.
// R4 - Release time equals full slide from upper to lower corner.
// R5 - Output level above threshold uses upper corner, below slides to lower.
// R6 - Threshold codes select 0.34 to 4.95 volts peak.
// R7 - Software keeps battery voltage setting equal to real speaker supply.
// R8 - Track continuous output power, briefly mute above threshold.
// R9 - Power threshold code 0 disables, others 0.05 to 1.80 W.
// R10 - Weighting splits influence between coil and magnet constants.
// R11 - Magnet constant 0 disables, others 0.50 to 8.88 minutes.
// R12 - Coil constant uses same table in seconds.
// R13 - Reduce output gain when clipped fraction exceeds distortion limit.
// R14 - Distortion limit 0 disables, 1 means below 1 percent, up to 24.
// R15 - Distortion release bit picks 1.4 s or 2.8 s.
// R16 - Excursion in digital path; power, distortion drive analog volume.
// R17 - Software changes excursion settings only while the path is off.
// R18 - Biquad coefficients stored in their documented sign forms.
// R19 - Software never writes reserved codes or invalid corner pairs.
module spl_limiters #(
	parameter int EXC_STEP = spl_pkg::EXC_STEP_CYCLES,
	parameter int DIST_STEP = spl_pkg::DIST_STEP_CYCLES,
	parameter int MUTE_LEN = spl_pkg::MUTE_CYCLES,
	parameter int PWR_TICK = spl_pkg::PWR_TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Speaker output monitor
	input wire logic mon_valid,
	input wire logic [15:0] mon_peak,
	input wire logic [12:0] battery_mv,
	input wire logic [10:0] mon_power_mw,
	input wire logic [7:0] mon_clip_permille,
	// Controls out
	output spl_pkg::spl_exc_ctl_t exc_ctl,
	output spl_pkg::spl_vol_ctl_t vol_ctl
);
	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] corner_r, thresh_r, release_r, pwr_tw_r, pwr_tc_r, dist_r;

	// Storage; only defined fields are kept, the rest read as zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			corner_r <= spl_pkg::REG_RESET;
			thresh_r <= spl_pkg::REG_RESET;
			release_r <= spl_pkg::REG_RESET;
			pwr_tw_r <= spl_pkg::REG_RESET;
			pwr_tc_r <= spl_pkg::REG_RESET;
			dist_r <= spl_pkg::REG_RESET;
		end else if (ce && reg_wr) begin
			case (reg_addr)
				spl_pkg::ADDR_CORNER: corner_r <= reg_wdata & 8'h73;
				spl_pkg::ADDR_THRESH: thresh_r <= reg_wdata & 8'h07;
				spl_pkg::ADDR_RELEASE: release_r <= reg_wdata & 8'h70;
				spl_pkg::ADDR_PWR_TW: pwr_tw_r <= reg_wdata & 8'hf7;
				spl_pkg::ADDR_PWR_TC: pwr_tc_r <= reg_wdata;
				spl_pkg::ADDR_DIST: dist_r <= reg_wdata & 8'hf1;
				default: ;
			endcase
		end
	end

	// Registered read data; unmapped addresses read zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			case (reg_addr)
				spl_pkg::ADDR_CORNER: reg_rdata <= corner_r;
				spl_pkg::ADDR_THRESH: reg_rdata <= thresh_r;
				spl_pkg::ADDR_RELEASE: reg_rdata <= release_r;
				spl_pkg::ADDR_PWR_TW: reg_rdata <= pwr_tw_r;
				spl_pkg::ADDR_PWR_TC: reg_rdata <= pwr_tc_r;
				spl_pkg::ADDR_DIST: reg_rdata <= dist_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Field extraction
	logic [2:0] upper_sel, release_sel, thresh_sel, weight_sel;
	logic [1:0] lower_sel;
	logic [3:0] pwr_sel, magnet_sel, coil_sel, dlim_sel;
	logic drel_sel;
	assign upper_sel = corner_r[spl_pkg::UPPER_LSB +: 3];
	assign lower_sel = corner_r[spl_pkg::LOWER_LSB +: 2];
	assign release_sel = release_r[spl_pkg::RELEASE_LSB +: 3];
	assign thresh_sel = thresh_r[spl_pkg::THRESH_LSB +: 3];
	assign pwr_sel = pwr_tw_r[spl_pkg::POWER_THRESHOLD_SEL_LSB +: 4];
	assign weight_sel = pwr_tw_r[spl_pkg::WEIGHT_LSB +: 3];
	assign magnet_sel = pwr_tc_r[spl_pkg::MAGNET_LSB +: 4];
	assign coil_sel = pwr_tc_r[spl_pkg::COIL_LSB +: 4];
	assign dlim_sel = dist_r[spl_pkg::DLIM_LSB +: 4];
	assign drel_sel = dist_r[spl_pkg::DREL_LSB];

	// ****************************************
	// Excursion limiter (digital path)
	// ****************************************
	spl_pkg::spl_exc_mode_t mode;
	logic [10:0] upper_hz, lower_hz;

	// Decode the corner pair; unlisted pairs are flagged, filter left fixed high
	always_comb begin
		mode = spl_pkg::EXC_INVALID;
		upper_hz = 11'd0;
		lower_hz = 11'd0;
		if (upper_sel <= 3'b100) begin
			upper_hz = spl_pkg::UPPER_HZ[upper_sel];
		end
		unique case (lower_sel)
			2'b00: mode = (upper_sel == 3'b000) ? spl_pkg::EXC_OFF : // R1
				(upper_sel <= 3'b100) ? spl_pkg::EXC_FIXED_PRESET : spl_pkg::EXC_INVALID;
			2'b01: if (upper_sel == 3'b001) begin
				mode = spl_pkg::EXC_DYN_PRESET; // R2
				lower_hz = spl_pkg::UPPER_HZ[0] + 11'd200;
			end
			2'b10: if (upper_sel == 3'b010 || upper_sel == 3'b011) begin
				mode = spl_pkg::EXC_DYN_PRESET; // R2
				lower_hz = spl_pkg::UPPER_HZ[1];
			end
			2'b11: mode = (upper_sel == 3'b000) ? spl_pkg::EXC_FIXED_BIQUAD : // R2
				(upper_sel <= 3'b100) ? spl_pkg::EXC_DYN_BIQUAD : spl_pkg::EXC_INVALID;
		endcase
	end

	// Output level in millivolts from full-scale peak and supply
	logic [28:0] level_prod;
	logic [12:0] level_mv;
	logic above;
	assign level_prod = mon_peak * battery_mv; // R7
	assign level_mv = level_prod[27:15];
	assign above = level_mv > spl_pkg::EXC_THR_MV[thresh_sel]; // R6

	// Slide step period; release codes 6 and 7 freeze the slide
	logic [31:0] exc_period, exc_cnt_r;
	logic [7:0] slide_r;
	logic dynamic;
	assign exc_period = 32'(EXC_STEP) << spl_pkg::REL_SHIFT[release_sel]; // R3
	assign dynamic = (mode == spl_pkg::EXC_DYN_PRESET) || (mode == spl_pkg::EXC_DYN_BIQUAD);

	// Attack is immediate; release walks 255 equal steps down to the low corner
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			slide_r <= spl_pkg::SLIDE_FULL;
			exc_cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			if (!dynamic) begin
				slide_r <= spl_pkg::SLIDE_FULL;
				exc_cnt_r <= 32'h0000_0000;
			end else if (mon_valid && above) begin
				slide_r <= spl_pkg::SLIDE_FULL; // R5
				exc_cnt_r <= 32'h0000_0000;
			end else if (release_sel[2:1] != 2'b11 && slide_r != 8'h00) begin
				if (exc_cnt_r + 32'h0000_0001 >= exc_period) begin
					exc_cnt_r <= 32'h0000_0000;
					slide_r <= slide_r - 8'h01; // R4
				end else begin
					exc_cnt_r <= exc_cnt_r + 32'h0000_0001;
				end
			end
		end
	end

	// Digital filter control, registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			exc_ctl <= '0;
		end else if (ce) begin
			exc_ctl.mode <= mode; // R16
			exc_ctl.upper_hz <= upper_hz;
			exc_ctl.lower_hz <= lower_hz;
			exc_ctl.slide <= slide_r;
		end
	end

	// ****************************************
	// Power limiter (analog volume)
	// ****************************************
	logic [31:0] tick_cnt_r;
	logic tick;
	logic [10:0] pwr_hold_r, coil_avg, magnet_avg;
	logic [15:0] coil_int, magnet_int;
	assign tick = tick_cnt_r + 32'h0000_0001 >= 32'(PWR_TICK);

	// Base tick is 1/64 of one hundredth of a second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
		end
	end

	// Hold the latest power sample between monitor updates
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwr_hold_r <= 11'd0;
		end else if (ce && mon_valid) begin
			pwr_hold_r <= mon_power_mw;
		end
	end

	assign coil_int = spl_pkg::TC_CS[coil_sel]; // R12
	assign magnet_int = 16'(spl_pkg::TC_CS[magnet_sel] * spl_pkg::SEC_PER_MIN); // R11

	spl_thermal_filter u_coil (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.tick(tick),
		.interval(coil_int),
		.power_mw(pwr_hold_r),
		.avg_mw(coil_avg)
	);

	spl_thermal_filter u_magnet (
		.clk(clk),
		.resetn(resetn),
		.ce(ce),
		.tick(tick),
		.interval(magnet_int),
		.power_mw(pwr_hold_r),
		.avg_mw(magnet_avg)
	);

	// Weighted estimate in eighths of the two averages
	logic [3:0] w_coil, w_magnet;
	logic [14:0] est_sum;
	logic [10:0] est_mw;
	logic [31:0] mute_cnt_r;
	assign w_coil = spl_pkg::COIL_EIGHTHS[weight_sel]; // R10
	assign w_magnet = spl_pkg::WEIGHT_ALL - w_coil;
	assign est_sum = coil_avg * w_coil + magnet_avg * w_magnet;
	assign est_mw = est_sum[13:3];

	// Mute stays for a fixed window, re-armed while the estimate stays high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mute_cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			if (pwr_sel != 4'h0 && est_mw > spl_pkg::PWR_THR_MW[pwr_sel]) begin // R9
				mute_cnt_r <= 32'(MUTE_LEN); // R8
			end else if (mute_cnt_r != 32'h0000_0000) begin
				mute_cnt_r <= mute_cnt_r - 32'h0000_0001;
			end
		end
	end

	// ****************************************
	// Distortion limiter (analog volume)
	// ****************************************
	logic [4:0] atten_r;
	logic [31:0] dist_cnt_r, dist_period;
	logic dist_over;
	assign dist_period = drel_sel ? 32'(DIST_STEP) << 1 : 32'(DIST_STEP); // R15
	assign dist_over = dlim_sel != 4'h0 && mon_valid &&
		mon_clip_permille > spl_pkg::THD_PERMILLE[dlim_sel]; // R14

	// One step down per over-limit sample, slow return toward nominal
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			atten_r <= 5'h00;
			dist_cnt_r <= 32'h0000_0000;
		end else if (ce) begin
			if (dlim_sel == 4'h0) begin
				atten_r <= 5'h00;
				dist_cnt_r <= 32'h0000_0000;
			end else if (dist_over) begin
				dist_cnt_r <= 32'h0000_0000;
				if (atten_r != spl_pkg::ATTEN_MAX) begin
					atten_r <= atten_r + 5'h01; // R13
				end
			end else if (atten_r != 5'h00) begin
				if (dist_cnt_r + 32'h0000_0001 >= dist_period) begin
					dist_cnt_r <= 32'h0000_0000;
					atten_r <= atten_r - 5'h01;
				end else begin
					dist_cnt_r <= dist_cnt_r + 32'h0000_0001;
				end
			end
		end
	end

	// Analog volume control, registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vol_ctl <= '0;
		end else if (ce) begin
			vol_ctl.mute <= mute_cnt_r != 32'h0000_0000; // R16
			vol_ctl.atten <= atten_r;
		end
	end
endmodule : spl_limiters
`default_nettype wire

// ===== testbench/spl_limiters_chk.sv
// Port-level concurrent checks of the speaker protection limiters
`timescale 1ns/1ps
`default_nettype none
module spl_limiters_chk #(
	parameter int EXC_STEP = 4,
	parameter int DIST_STEP = 4,
	parameter int MUTE_LEN = 8,
	parameter int PWR_TICK = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// Register port
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Speaker output monitor
	input wire logic mon_valid,
	input wire logic [15:0] mon_peak,
	input wire logic [12:0] battery_mv,
	input wire logic [10:0] mon_power_mw,
	input wire logic [7:0] mon_clip_permille,
	// Controls out
	input wire spl_pkg::spl_exc_ctl_t exc_ctl,
	input wire spl_pkg::spl_vol_ctl_t vol_ctl
);
	// ****************************************
	// Assertions, one clock domain
	// ****************************************
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_unmapped_zero: assert property (ce && !(reg_addr inside {[8'h41:8'h46]})
		|=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	// The slide output trails a mode change by one cycle, so the mode must have settled
	chk_fixed_upper: assert property (exc_ctl.mode inside {spl_pkg::EXC_FIXED_PRESET,
		spl_pkg::EXC_FIXED_BIQUAD} && exc_ctl.mode == $past(exc_ctl.mode)
		|-> exc_ctl.slide == 8'hff) else $error("fixed mode slid");
	chk_invalid_hold: assert property (exc_ctl.mode == spl_pkg::EXC_INVALID
		&& $past(exc_ctl.mode) == spl_pkg::EXC_INVALID
		|-> exc_ctl.slide == 8'hff) else $error("invalid corner pair slid");
	chk_slide_single: assert property (exc_ctl.slide < $past(exc_ctl.slide)
		|-> exc_ctl.slide == $past(exc_ctl.slide) - 8'h01) else $error("slide jumped down");
	// Shortest step is EXC_STEP cycles, so three quiet cycles follow each step
	chk_slide_pace: assert property (exc_ctl.slide < $past(exc_ctl.slide)
		|=> (exc_ctl.slide >= $past(exc_ctl.slide)) [*3]) else $error("slide stepped too fast");
	chk_slide_rearm: assert property (ce && mon_valid && mon_peak == 16'hffff
		&& battery_mv >= 13'h1000
		&& exc_ctl.mode inside {spl_pkg::EXC_DYN_PRESET, spl_pkg::EXC_DYN_BIQUAD}
		##1 ce |=> exc_ctl.slide == 8'hff) else $error("loud sample did not raise corner");
	chk_atten_step: assert property (vol_ctl.atten > $past(vol_ctl.atten)
		|-> vol_ctl.atten == $past(vol_ctl.atten) + 5'h01) else $error("atten rose by more than one");
	chk_atten_cause: assert property (vol_ctl.atten > $past(vol_ctl.atten)
		|-> $past(mon_valid, 2)) else $error("atten rose without a sample");
	chk_mute_hold: assert property ($rose(vol_ctl.mute) |=> vol_ctl.mute [*6])
		else $error("mute too short");
endmodule : spl_limiters_chk

bind spl_limiters spl_limiters_chk #(.EXC_STEP(EXC_STEP), .DIST_STEP(DIST_STEP),
	.MUTE_LEN(MUTE_LEN), .PWR_TICK(PWR_TICK)) u_spl_limiters_chk (.clk(clk), .resetn(resetn),
	.ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.mon_valid(mon_valid), .mon_peak(mon_peak), .battery_mv(battery_mv),
	.mon_power_mw(mon_power_mw), .mon_clip_permille(mon_clip_permille), .exc_ctl(exc_ctl),
	.vol_ctl(vol_ctl));
`default_nettype wire

// ===== testbench/spl_limiters_bench.sv
// Self-checking bench of the speaker protection limiters
`timescale 1ns/1ps
`default_nettype none
module spl_limiters_bench;
`define CHK(o, e) begin total_checks++; if ((o) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h exp %h", $time, o, e); end end
	logic clk = 0, resetn = 0, ce = 1, reg_wr = 0, mon_valid = 0, rd = 0, rd_d = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, clip = 0, reg_rdata, ex;
	logic [15:0] mon_peak = 0;
	logic [12:0] batt = 13'h1000;
	logic [10:0] pwr = 0;
	logic [31:0] rnd = 32'h5cec;
	logic [7:0] q[$];
	spl_pkg::spl_exc_ctl_t exc_ctl;
	spl_pkg::spl_vol_ctl_t vol_ctl;
	int err_total = 0, total_checks = 0, cyc = 0, n, i, j, st, xp;
	int cc[12] = '{'h00, 'h10, 'h20, 'h30, 'h40, 'h03, 'h11, 'h22, 'h32, 'h13, 'h43, 'h12};
	int cm[12] = '{0, 1, 1, 1, 1, 2, 3, 3, 3, 4, 4, 5};
	int cu[12] = '{-1, 400, 600, 800, 1000, -1, 400, 600, 800, 400, 1000, -1};
	int cl[12] = '{-1, -1, -1, -1, -1, -1, 200, 400, 400, 0, 0, -1};
	int th[8] = '{340, 710, 1300, 1770, 2330, 3250, 4250, 4950};
	int dp[16] = '{0, 5, 10, 20, 40, 60, 80, 100, 120, 140, 160, 180, 200, 210, 220, 240};

	spl_limiters #(.EXC_STEP(4), .DIST_STEP(4), .MUTE_LEN(8), .PWR_TICK(2)) u_spl_limiters (
		.clk(clk), .resetn(resetn), .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mon_valid(mon_valid), .mon_peak(mon_peak),
		.battery_mv(batt), .mon_power_mw(pwr), .mon_clip_permille(clip), .exc_ctl(exc_ctl),
		.vol_ctl(vol_ctl));

	// ****************************************
	// Clock, watcher and helpers
	// ****************************************
	always #2 clk = ~clk;

	// Read data lands one edge after the address, so notes are taken two edges on
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_d <= rd;
		if (rd_d) begin
			ex = q.pop_front();
			`CHK(reg_rdata, ex)
		end
		if (cyc == 90000) begin
			err_total++;
			stop_test();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] msk(input logic [7:0] a);
		case (a)
			8'h41: return 8'h73;
			8'h42: return 8'h07;
			8'h43: return 8'h70;
			8'h44: return 8'hf7;
			8'h45: return 8'hff;
			8'h46: return 8'hf1;
			default: return 8'h00;
		endcase
	endfunction : msk

	task automatic tk(input int k);
		repeat (k) @(posedge clk);
	endtask : tk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 0;
	endtask : wr

	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		rd <= 1;
		q.push_back(e);
		@(posedge clk);
		rd <= 0;
	endtask : rdx

	task automatic mon(input logic [15:0] p, input logic [7:0] c);
		@(posedge clk);
		mon_valid <= 1;
		mon_peak <= p;
		clip <= c;
		@(posedge clk);
		mon_valid <= 0;
	endtask : mon

	// Cycles until the attenuation next moves, bounded so a stuck design cannot hang
	task automatic wch(output int k);
		logic [4:0] a;
		a = vol_ctl.atten;
		k = 0;
		while (vol_ctl.atten === a && k < 500) begin
			@(posedge clk);
			k++;
		end
	endtask : wch

	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		tk(2);
		resetn <= 1;
		// Reset values, masked random writes, unmapped neighbours
		for (i = 0; i < 8; i++) rdx(8'h40 + 8'(i), 8'h00);
		wr(8'h47, 8'hff);
		for (i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			wr(8'h40 + 8'(i), rnd[7:0]);
			rdx(8'h40 + 8'(i), rnd[7:0] & msk(8'h40 + 8'(i)));
		end
		// Every corner combination except biquad-to-600 and biquad-to-800 Hz, plus one invalid pair
		for (i = 0; i < 12; i++) begin
			wr(8'h41, 8'(cc[i]));
			tk(3);
			`CHK(exc_ctl.mode, 3'(cm[i]))
			if (cu[i] >= 0) `CHK(exc_ctl.upper_hz, 11'(cu[i]))
			if (cl[i] >= 0) `CHK(exc_ctl.lower_hz, 11'(cl[i]))
		end
		wr(8'h41, 8'h11);
		wr(8'h42, 8'h00);
		// Full slide time for release codes 0 to 5
		for (i = 0; i < 6; i++) begin
			st = 4 << ((i > 3) ? 0 : 4 - i);
			xp = 255 * st;
			wr(8'h43, 8'(i << 4));
			mon(16'hffff, 8'h00);
			tk(2);
			n = 0;
			while (exc_ctl.slide !== 8'h00 && n < 20000) begin
				@(posedge clk);
				n++;
			end
			`CHK(n + st + 4 >= xp && n <= xp + st + 4, 1'b1)
		end
		wr(8'h43, 8'h60);
		mon(16'hffff, 8'h00);
		tk(50);
		`CHK(exc_ctl.slide, 8'hff)
		// Each threshold code, just below and just above its level
		wr(8'h43, 8'h40);
		for (i = 0; i < 8; i++) begin
			wr(8'h42, 8'(i));
			mon(16'hffff, 8'h00);
			tk(40);
			mon(16'(th[i] * 8 - 16), 8'h00);
			tk(3);
			`CHK(exc_ctl.slide !== 8'hff, 1'b1)
			mon(16'(th[i] * 8 + 16), 8'h00);
			tk(3);
			`CHK(exc_ctl.slide, 8'hff)
		end
		// Each distortion limit, at and one above its figure
		for (i = 1; i < 16; i++) begin
			wr(8'h46, 8'(i << 4));
			tk(10);
			mon(16'h0000, 8'(dp[i]));
			tk(2);
			`CHK(vol_ctl.atten, 5'h00)
			mon(16'h0000, 8'(dp[i] + 1));
			tk(2);
			`CHK(vol_ctl.atten, 5'h01)
		end
		for (j = 0; j < 2; j++) begin
			wr(8'h46, 8'h20 | 8'(j));
			repeat (100) mon(16'h0000, 8'hff);
			`CHK(vol_ctl.atten >= 5'h1e, 1'b1)
			wch(n);
			wch(n);
			`CHK(n, 4 * (j + 1))
		end
		wr(8'h46, 8'h00);
		mon(16'h0000, 8'hff);
		tk(2);
		`CHK(vol_ctl.atten, 5'h00)
		// Power limiter: disabled, then enabled on the coil constant alone
		pwr <= 11'h708;
		wr(8'h45, 8'h01);
		wr(8'h44, 8'h04);
		// Power is only taken with a monitor sample, so present one
		mon(16'h0000, 8'h00);
		tk(600);
		`CHK(vol_ctl.mute, 1'b0)
		wr(8'h44, 8'h14);
		n = 0;
		while (vol_ctl.mute !== 1'b1 && n < 600) begin
			@(posedge clk);
			n++;
		end
		`CHK(vol_ctl.mute, 1'b1)
		wr(8'h45, 8'h0c);
		tk(20);
		`CHK(vol_ctl.mute, 1'b0)
		// Clock enable low freezes the attenuation release
		wr(8'h46, 8'h20);
		mon(16'h0000, 8'hff);
		tk(2);
		ce <= 0;
		tk(20);
		`CHK(vol_ctl.atten, 5'h01)
		ce <= 1;
		tk(10);
		`CHK(vol_ctl.atten, 5'h00)
		stop_test();
	end
endmodule : spl_limiters_bench
`default_nettype wire
